// ===== verif/csa_arbiter_asserts.sv
/*
 * csa_arbiter_chk: concurrent checks on the arbiter top ports.
 * assumes one clock domain and three-stage pin synchronisers.
 */
`timescale 1ns/1ps
module csa_arbiter_chk (
    input wire logic                 i_clock,
    input wire logic                 i_rst,
    input wire logic                 i_has_panel,
    input wire logic                 i_disable_pin,
    input wire csa_pkg::csa_btn_type i_buttons,
    input wire csa_pkg::csa_cmd_type i_cmd,
    input wire logic                 i_cv_regulating,
    input wire logic                 o_output_on,
    input wire logic                 o_ramp_enable,
    input wire csa_pkg::csa_src_type o_source,
    input wire logic [1:0]           o_active_iface,
    input wire logic                 o_remote_led,
    input wire logic                 o_listen_en,
    input wire logic                 o_cmd_refused,
    input wire logic                 o_error,
    input wire logic                 o_regulation_state_output
);
    logic [3:0] idle_q;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    // cycles since a button that may turn the output on was last high
    always_ff @(posedge i_clock) begin
        if (i_rst || i_buttons.on_btn || i_buttons.toggle_btn) begin
            idle_q <= 4'h0;
        end else if (idle_q != 4'hF) begin
            idle_q <= idle_q + 4'h1;
        end
    end

    refuse_pulse_a: assert property (i_cmd.valid && i_has_panel && o_source == csa_pkg::SRC_ANALOG
        |=> o_cmd_refused && o_source == csa_pkg::SRC_ANALOG) else $error("analog to digital not refused");
    panelless_take_a: assert property (i_cmd.valid && !i_has_panel && !o_listen_en
        && o_source == csa_pkg::SRC_ANALOG |=> o_source == csa_pkg::SRC_REMOTE && !o_cmd_refused)
        else $error("panelless unit kept analog");
    no_panel_a: assert property (!i_has_panel |-> o_source != csa_pkg::SRC_PANEL)
        else $error("panel mode on panelless unit");
    disable_off_a: assert property ((!i_disable_pin) [*7] |-> !o_output_on)
        else $error("output on while disabled");
    src_rise_on_a: assert property ($rose(o_output_on) && o_source != csa_pkg::SRC_ANALOG
        |-> idle_q < 4'h8) else $error("output on without button");
    error_off_a: assert property (o_error [*2] |-> !o_output_on) else $error("output on with error");
    set_remote_a: assert property (i_cmd.valid && i_cmd.is_set && o_source inside {csa_pkg::SRC_PANEL,
        csa_pkg::SRC_REMOTE} |=> o_source == csa_pkg::SRC_REMOTE && o_active_iface == $past(i_cmd.iface))
        else $error("set command did not take control");
    listen_hold_a: assert property (o_listen_en && i_cmd.valid && !i_cmd.is_set
        |=> $stable(o_source) && $stable(o_active_iface)) else $error("listener took control");
    led_follow_a: assert property ($rose(o_source == csa_pkg::SRC_REMOTE) |=> o_remote_led)
        else $error("remote indicator dark");
    ramp_gate_a: assert property (o_ramp_enable |-> $past(o_output_on))
        else $error("ramp without output");
    cv_pin_a: assert property ($stable(i_cv_regulating) [*8]
        |-> o_regulation_state_output == i_cv_regulating) else $error("regulation state wrong");
endmodule

bind csa_arbiter csa_arbiter_chk u_chk (.i_clock, .i_rst, .i_has_panel, .i_disable_pin, .i_buttons, .i_cmd,
    .i_cv_regulating, .o_output_on, .o_ramp_enable, .o_source, .o_active_iface, .o_remote_led, .o_listen_en,
    .o_cmd_refused, .o_error, .o_regulation_state_output);

// ===== verif/csa_far_side.sv
/*
 * csa_far_side: host, analog controller and panel buttons in one model.
 * assumes it is driven by tasks at the falling clock edge.
 */
`timescale 1ns/1ps
module csa_far_side (
    input  wire logic            i_clock,
    output logic                 o_disable_pin = 1'b1,
    output logic                 o_on_pin = 1'b0,
    output csa_pkg::csa_btn_type o_buttons = 3'h0,
    output csa_pkg::csa_cmd_type o_cmd,
    output logic                 o_listen_cfg = 1'b0,
    output logic                 o_listen_cfg_en = 1'b0
);
    logic       cmd_v = 1'b0;
    logic [2:0] cmd_f = 3'h0;
    logic [2:0] junk  = 3'h0;

    // idle command fields churn so nothing can lean on stale values
    always @(posedge i_clock) junk <= junk + 3'h3;
    assign o_cmd = cmd_v ? {1'b1, cmd_f} : {1'b0, junk};

    task automatic send(input logic [1:0] ifc, input logic set);
        @(negedge i_clock);
        cmd_f = {set, ifc};
        cmd_v = 1'b1;
        @(negedge i_clock);
        cmd_v = 1'b0;
    endtask

    task automatic listen(input logic v);
        @(negedge i_clock);
        o_listen_cfg = v;
        o_listen_cfg_en = 1'b1;
        @(negedge i_clock);
        o_listen_cfg_en = 1'b0;
    endtask

    task automatic press(input int b);
        @(negedge i_clock);
        o_buttons[b] = 1'b1;
        repeat (8) @(negedge i_clock);
        o_buttons[b] = 1'b0;
    endtask

    task automatic pins(input logic dis, input logic on);
        @(negedge i_clock);
        o_disable_pin = dis;
        o_on_pin = on;
    endtask
endmodule

// ===== verif/tb_top.sv
/*
 * tb_top: self-checking bench of the control source arbiter.
 * assumes the far-side model drives pins and commands.
 */
`timescale 1ns/1ps
module tb_top;
    logic                 i_clock = 1'b0;
    logic                 i_rst   = 1'b1;
    logic                 has_p   = 1'b1;
    logic                 st_an   = 1'b0;
    logic                 e_set   = 1'b0;
    logic                 e_ack   = 1'b0;
    logic                 cv      = 1'b1;
    logic                 lsn     = 1'b0;
    logic [15:0]          av = 16'h0000, ai = 16'h0000, dv = 16'h0000, di = 16'h0000;
    logic                 dis, on_p, l_cfg, l_en, out_on, ramp, led, lis, refd, err, reg_o;
    logic [1:0]           iface;
    logic [1:0]           ifc = 2'h0;
    logic [15:0]          vset, iset;
    csa_pkg::csa_btn_type btns;
    csa_pkg::csa_cmd_type cmd;
    csa_pkg::csa_src_type src;
    logic [43:0]          q_exp[$];
    logic [43:0]          got;
    int                   fails = 0;
    int                   checks = 0;
    int                   cycles = 0;
    int                   seed = 32'h72e9ac91;
    event                 chk_ev;

    always #2 i_clock = ~i_clock;

    csa_far_side far (.i_clock(i_clock), .o_disable_pin(dis), .o_on_pin(on_p), .o_buttons(btns), .o_cmd(cmd),
        .o_listen_cfg(l_cfg), .o_listen_cfg_en(l_en));

    csa_arbiter uut (.i_clock(i_clock), .i_rst(i_rst), .i_has_panel(has_p), .i_stored_analog(st_an),
        .i_disable_pin(dis), .i_analog_on_pin(on_p), .i_buttons(btns), .i_cmd(cmd), .i_listen_cfg(l_cfg),
        .i_listen_cfg_en(l_en), .i_error_set(e_set), .i_error_ack_other(e_ack), .i_cv_regulating(cv),
        .i_analog_vset(av), .i_analog_iset(ai), .i_digital_vset(dv), .i_digital_iset(di),
        .o_output_on(out_on), .o_ramp_enable(ramp), .o_source(src), .o_active_iface(iface), .o_remote_led(led),
        .o_listen_en(lis), .o_cmd_refused(refd), .o_error(err), .o_regulation_state_output(reg_o),
        .o_vset(vset), .o_iset(iset));

    // ------------------------------------------------------------
    // checking
    // ------------------------------------------------------------
    task automatic test_done();
        if (fails == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    always @(chk_ev) begin
        checks++;
        got = {src, iface, out_on, led, err, reg_o, ramp, lis, vset, iset};
        if (got !== q_exp[0]) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, q_exp[0]);
        end
        void'(q_exp.pop_front());
    end

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 8000) begin
            fails++;
            test_done();
        end
    end

    // outputs are looked at only once every pin path has settled
    task automatic exp_st(input csa_pkg::csa_src_type s, input logic on, input logic l, input logic e);
        {av, ai} = $random(seed);
        {dv, di} = $random(seed);
        repeat (10) @(negedge i_clock);
        q_exp.push_back({s, ifc, on, l, e, cv, on & dis, lsn, (s == csa_pkg::SRC_ANALOG ? {av, ai} : {dv, di})});
        -> chk_ev;
    endtask

    task automatic do_reset(input logic p, input logic a);
        @(negedge i_clock);
        i_rst = 1'b1;
        has_p = p;
        st_an = a;
        ifc = csa_pkg::RST_IFACE;
        lsn = csa_pkg::RST_LISTEN_EN;
        // the analog on pin goes back to idle so no false edge follows release
        far.pins(1'b1, 1'b0);
        repeat (3) @(negedge i_clock);
        i_rst = 1'b0;
    endtask

    task automatic pulse(input logic ack);
        @(negedge i_clock);
        e_ack = ack;
        e_set = !ack;
        @(negedge i_clock);
        e_ack = 1'b0;
        e_set = 1'b0;
    endtask

    task automatic rnd_send(input logic set);
        ifc = 2'($random(seed));
        far.send(ifc, set);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        for (int k = 0; k < 3; k++) begin
            do_reset(k != 1, k == 2);
            exp_st(k == 0 ? csa_pkg::SRC_PANEL : csa_pkg::SRC_ANALOG, 1'b0, 1'b0, 1'b0);
        end
        far.send(2'h3, 1'b1);
        exp_st(csa_pkg::SRC_ANALOG, 1'b0, 1'b0, 1'b0);
        pulse(1'b0);
        exp_st(csa_pkg::SRC_ANALOG, 1'b0, 1'b0, 1'b1);
        far.pins(1'b0, 1'b0);
        exp_st(csa_pkg::SRC_ANALOG, 1'b0, 1'b0, 1'b1);
        far.pins(1'b1, 1'b0);
        exp_st(csa_pkg::SRC_ANALOG, 1'b1, 1'b0, 1'b0);
        far.pins(1'b1, 1'b1);
        exp_st(csa_pkg::SRC_ANALOG, 1'b1, 1'b0, 1'b0);
        far.pins(1'b1, 1'b0);
        exp_st(csa_pkg::SRC_ANALOG, 1'b0, 1'b0, 1'b0);
        far.pins(1'b1, 1'b1);
        exp_st(csa_pkg::SRC_ANALOG, 1'b1, 1'b0, 1'b0);
        do_reset(1'b0, 1'b0);
        rnd_send(1'b0);
        exp_st(csa_pkg::SRC_REMOTE, 1'b0, 1'b1, 1'b0);
        do_reset(1'b1, 1'b0);
        far.press(2);
        far.pins(1'b0, 1'b0);
        exp_st(csa_pkg::SRC_PANEL, 1'b0, 1'b0, 1'b0);
        far.pins(1'b1, 1'b0);
        exp_st(csa_pkg::SRC_PANEL, 1'b0, 1'b0, 1'b0);
        for (int b = 1; b >= 0; b--) begin
            far.press(2);
            exp_st(csa_pkg::SRC_PANEL, 1'b1, 1'b0, 1'b0);
            rnd_send(1'b0);
            exp_st(csa_pkg::SRC_REMOTE, 1'b1, 1'b1, 1'b0);
            far.press(b);
            exp_st(csa_pkg::SRC_PANEL, 1'b0, 1'b0, 1'b0);
        end
        lsn = 1'b1;
        far.listen(1'b1);
        far.send(ifc + 2'h1, 1'b0);
        exp_st(csa_pkg::SRC_PANEL, 1'b0, 1'b0, 1'b0);
        rnd_send(1'b1);
        exp_st(csa_pkg::SRC_REMOTE, 1'b0, 1'b1, 1'b0);
        pulse(1'b0);
        exp_st(csa_pkg::SRC_REMOTE, 1'b0, 1'b1, 1'b1);
        pulse(1'b1);
        exp_st(csa_pkg::SRC_REMOTE, 1'b0, 1'b1, 1'b0);
        for (int n = 0; n < 4; n++) begin
            @(negedge i_clock);
            cv = 1'($random(seed));
            exp_st(csa_pkg::SRC_REMOTE, 1'b0, 1'b1, 1'b0);
        end
        test_done();
    end
endmodule

// ===== verilog/csa_arbiter.sv
/*
 * csa_arbiter: decides which source controls the supply output.
 * assumes command events are one-cycle pulses on i_clock; disable,
 * on and button pins are asynchronous; regulation flag is a pin too.
 */
`timescale 1ns/1ps
module csa_arbiter #(
    parameter int unsigned IFACES = csa_pkg::NUM_IFACES
) (
    input  wire logic                 i_clock,
    input  wire logic                 i_rst,
    input  wire logic                 i_has_panel,
    input  wire logic                 i_stored_analog,
    input  wire logic                 i_disable_pin,
    input  wire logic                 i_analog_on_pin,
    input  wire csa_pkg::csa_btn_type i_buttons,
    input  wire csa_pkg::csa_cmd_type i_cmd,
    input  wire logic                 i_listen_cfg,
    input  wire logic                 i_listen_cfg_en,
    input  wire logic                 i_error_set,
    input  wire logic                 i_error_ack_other,
    input  wire logic                 i_cv_regulating,
    input  wire logic [15:0]          i_analog_vset,
    input  wire logic [15:0]          i_analog_iset,
    input  wire logic [15:0]          i_digital_vset,
    input  wire logic [15:0]          i_digital_iset,
    output logic                      o_output_on,
    output logic                      o_ramp_enable,
    output csa_pkg::csa_src_type      o_source,
    output logic [1:0]                o_active_iface,
    output logic                      o_remote_led,
    output logic                      o_listen_en,
    output logic                      o_cmd_refused,
    output logic                      o_error,
    output logic                      o_regulation_state_output,
    output logic [15:0]               o_vset,
    output logic [15:0]               o_iset
);

    // ------------------------------------------------------------
    // synchronised pins
    // ------------------------------------------------------------
    // open disable pin reads high, so idle level is high
    // the analog on pin and the buttons idle low; a pin held high across
    // reset shows one rise a few cycles after release, which is accepted
    // only by the source that owns that pin at that moment
    // fall outputs of the button synchronisers are left unread on purpose
    logic dis_level, dis_rise, dis_fall;
    logic aon_level, aon_rise, aon_fall;
    logic on_lvl, on_rise, on_fall;
    logic tog_lvl, tog_rise, tog_fall;
    logic men_lvl, men_rise, men_fall;
    logic cv_lvl, cv_rise, cv_fall;

    csa_sync #(.RST_VAL(1'b1)) u_dis (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_pin   (i_disable_pin),
        .o_level (dis_level),
        .o_rise  (dis_rise),
        .o_fall  (dis_fall)
    );
    csa_sync #(.RST_VAL(1'b0)) u_aon (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_pin   (i_analog_on_pin),
        .o_level (aon_level),
        .o_rise  (aon_rise),
        .o_fall  (aon_fall)
    );
    csa_sync #(.RST_VAL(1'b0)) u_on (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_pin   (i_buttons.on_btn),
        .o_level (on_lvl),
        .o_rise  (on_rise),
        .o_fall  (on_fall)
    );
    csa_sync #(.RST_VAL(1'b0)) u_tog (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_pin   (i_buttons.toggle_btn),
        .o_level (tog_lvl),
        .o_rise  (tog_rise),
        .o_fall  (tog_fall)
    );
    csa_sync #(.RST_VAL(1'b0)) u_men (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_pin   (i_buttons.menu_btn),
        .o_level (men_lvl),
        .o_rise  (men_rise),
        .o_fall  (men_fall)
    );
    csa_sync #(.RST_VAL(1'b1)) u_cv (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_pin   (i_cv_regulating),
        .o_level (cv_lvl),
        .o_rise  (cv_rise),
        .o_fall  (cv_fall)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_digital(input csa_pkg::csa_src_type s);
        is_digital = (s == csa_pkg::SRC_REMOTE) || (s == csa_pkg::SRC_LISTEN);
    endfunction

    function automatic logic is_analog(input csa_pkg::csa_src_type s);
        is_analog = (s == csa_pkg::SRC_ANALOG);
    endfunction

    // ------------------------------------------------------------
    // power-on strap capture
    // ------------------------------------------------------------
    // straps are sampled on the first clock after reset release
    // a later i_stored_analog change takes effect only through a new reset; i_has_panel is read live
    logic boot_pending_q;
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            boot_pending_q <= 1'b1;
        end else begin
            boot_pending_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // listening enable
    // ------------------------------------------------------------
    // the host's configuration command arrives as i_listen_cfg_en
    // the setting survives source changes and is cleared only by reset or a configuration command
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_listen_en <= csa_pkg::RST_LISTEN_EN;
        end else if (i_listen_cfg_en) begin
            o_listen_en <= i_listen_cfg;
        end
    end

    // ------------------------------------------------------------
    // control source
    // ------------------------------------------------------------
    logic panel_press;
    logic cmd_allowed;
    assign panel_press = tog_rise | men_rise;
    // panel units stored as analog may never hand over directly
    assign cmd_allowed = i_cmd.valid && !(is_analog(o_source) && i_has_panel);

    // refusal is a one-cycle pulse per refused command; the host must
    // resend once the control setting has gone back to panel
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_cmd_refused <= 1'b0;
        end else begin
            o_cmd_refused <= i_cmd.valid && !cmd_allowed;
        end
    end

    // the listening source code is kept for a later per-interface split;
    // today a listener never owns control, so no path enters it
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_source       <= csa_pkg::SRC_ANALOG;
            o_active_iface <= csa_pkg::RST_IFACE;
        end else begin
            if (boot_pending_q) begin
                if (i_has_panel && !i_stored_analog) begin
                    o_source <= csa_pkg::SRC_PANEL;
                end else begin
                    o_source <= csa_pkg::SRC_ANALOG;
                end
            end else if (cmd_allowed) begin
                case (o_source)
                    csa_pkg::SRC_LISTEN: begin
                        if (i_cmd.is_set) begin
                            o_source       <= csa_pkg::SRC_REMOTE;
                            o_active_iface <= i_cmd.iface;
                        end
                    end
                    csa_pkg::SRC_REMOTE: begin
                        if (i_cmd.is_set || !o_listen_en) begin
                            o_active_iface <= i_cmd.iface;
                        end
                    end
                    csa_pkg::SRC_ANALOG,
                    csa_pkg::SRC_PANEL: begin
                        if (o_listen_en && !i_cmd.is_set) begin
                            o_source <= o_source;
                        end else begin
                            o_source       <= csa_pkg::SRC_REMOTE;
                            o_active_iface <= i_cmd.iface;
                        end
                    end
                    default: begin
                        o_source <= csa_pkg::SRC_ANALOG;
                    end
                endcase
            end else if (i_has_panel && panel_press && o_source == csa_pkg::SRC_REMOTE) begin
                o_source <= csa_pkg::SRC_PANEL;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_remote_led <= 1'b0;
        end else begin
            o_remote_led <= is_digital(o_source);
        end
    end

    // ------------------------------------------------------------
    // blocking error
    // ------------------------------------------------------------
    // the disable rise that acknowledges under analog control also turns
    // the output on, so the acknowledge releases the block in that cycle
    logic err_ack;
    logic err_block;
    assign err_ack   = i_error_ack_other || (dis_rise && is_analog(o_source));
    // a new error wins over an acknowledge in the same cycle
    assign err_block = i_error_set || (o_error && !err_ack);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_error <= 1'b0;
        end else if (i_error_set) begin
            o_error <= 1'b1;
        end else if (err_ack) begin
            o_error <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // output on/off
    // ------------------------------------------------------------
    // digital on/off commands are handled by the command decoder outside;
    // this block only owns the hardware-level switching paths
    logic turn_on;
    logic turn_off;
    // a falling analog on pin switches off even when the disable rise turned on
    always_comb begin
        turn_on  = 1'b0;
        turn_off = 1'b0;
        case (o_source)
            csa_pkg::SRC_ANALOG: begin
                turn_on  = dis_rise || (aon_rise && dis_level);
                turn_off = aon_fall;
            end
            csa_pkg::SRC_PANEL: begin
                turn_on  = on_rise || (tog_rise && !o_output_on);
            end
            csa_pkg::SRC_REMOTE,
            csa_pkg::SRC_LISTEN: begin
                turn_off = panel_press && i_has_panel;
            end
            default: begin
                turn_off = 1'b1;
            end
        endcase
        if (o_source == csa_pkg::SRC_PANEL && tog_rise && o_output_on) begin
            turn_off = 1'b1;
        end
        if (!dis_level) begin
            turn_off = 1'b1;
            turn_on  = 1'b0;
        end
        if (err_block) begin
            turn_on  = 1'b0;
            turn_off = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || boot_pending_q) begin
            o_output_on <= csa_pkg::RST_OUTPUT_ON;
        end else if (turn_off) begin
            o_output_on <= 1'b0;
        end else if (turn_on) begin
            o_output_on <= 1'b1;
        end
    end

    // ramping is allowed only while the disable pin permits generation
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_ramp_enable <= 1'b0;
        end else begin
            o_ramp_enable <= o_output_on && dis_level;
        end
    end

    // ------------------------------------------------------------
    // set point routing
    // ------------------------------------------------------------
    // panel and digital sources share the digital set points; the panel
    // encoders are merged into them outside this block
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_vset <= 16'h0000;
            o_iset <= 16'h0000;
        end else if (is_analog(o_source)) begin
            o_vset <= i_analog_vset;
            o_iset <= i_analog_iset;
        end else begin
            o_vset <= i_digital_vset;
            o_iset <= i_digital_iset;
        end
    end

    // ------------------------------------------------------------
    // regulation state pin
    // ------------------------------------------------------------
    // resets high: until the first sample the supply is reported as CV
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_regulation_state_output <= 1'b1;
        end else begin
            o_regulation_state_output <= cv_lvl;
        end
    end

endmodule

// ===== verilog/csa_pkg.sv
/*
 * csa_pkg: shared types and constants of the control source arbiter.
 * assumes a single 250 MHz clock domain; nothing else.
 */
package csa_pkg;

    // ------------------------------------------------------------
    // control sources
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SRC_PANEL  = 4'h1,
        SRC_ANALOG = 4'h2,
        SRC_REMOTE = 4'h4,
        SRC_LISTEN = 4'h8
    } csa_src_type;

    localparam int unsigned NUM_IFACES = 4;

    // ------------------------------------------------------------
    // command event from the digital interfaces
    // ------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       is_set;
        logic [1:0] iface;
    } csa_cmd_type;

    // ------------------------------------------------------------
    // panel button strobes (raw pins)
    // ------------------------------------------------------------
    typedef struct packed {
        logic on_btn;
        logic toggle_btn;
        logic menu_btn;
    } csa_btn_type;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic       RST_OUTPUT_ON  = 1'b0;
    localparam logic       RST_LISTEN_EN  = 1'b0;
    localparam logic [1:0] RST_IFACE      = 2'h0;
    localparam logic [2:0] RST_SYNC       = 3'h7;
    localparam int unsigned SYNC_STAGES   = 3;

endpackage

// ===== verilog/csa_sync.sv
/*
 * csa_sync: three-stage input synchroniser with edge detect.
 * assumes an asynchronous level input; reset value set by parameter.
 */
`timescale 1ns/1ps
module csa_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic i_clock,
    input  wire logic i_rst,
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);

    logic [2:0] sync_q;

    // ------------------------------------------------------------
    // capture
    // ------------------------------------------------------------
    // stage 0 is read only by stage 1; a change counts once 1 and 2 agree
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sync_q  <= {3{RST_VAL}};
            o_level <= RST_VAL;
            o_rise  <= 1'b0;
            o_fall  <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], i_pin};
            o_rise <= 1'b0;
            o_fall <= 1'b0;
            if (sync_q[1] == sync_q[2] && sync_q[2] != o_level) begin
                o_level <= sync_q[2];
                o_rise  <= sync_q[2];
                o_fall  <= ~sync_q[2];
            end
        end
    end

endmodule
